// file: inc/itb_params.svh
// Contract
// - Own target address sits in bits 25..31 of target config, resets to 0x30.
// - Device answers at its own address only while target response enable is set.
// - Two low address bits are captured from configuration pins at power-up.
// - Writes to the pin-latched low bits are ignored unless unlock is written one.
// - After every reset a boot load starts from EEPROM using reset contents.
// - Some boot control fields take reset values from pins sampled at power-up.
// - Loaded EEPROM data may overwrite boot control during boot.
// - After boot ends, boot control stays read/write but has no effect.
// - Other field writes update storage but do not alter boot without chain.
// - With response disabled, all transfers are refused except enabled alert reads.
// - Low-bits unlock resets to zero; writers set it in the changing write.
`ifndef ITB_PARAMS_SVH
`define ITB_PARAMS_SVH
`define ITB_OFF_TGT_CFG 32'h0001_D13C
`define ITB_OFF_BOOT 32'h0001_D140
`define ITB_OFF_STATUS 32'h0001_D144
`define ITB_ADDR_RST 7'h30
// Target config reset: response enabled, own address at its reset value
`define ITB_TGT_RST 32'h1000_0030
// Boot control reset: page increment set, straps fill in offset size and the two low device address bits
`define ITB_BOOT_RST 32'h2000_0000
`define ITB_ALERT_ADDR 7'h0C
`define ITB_GCALL_ADDR 7'h00
// Bit positions in LSB-0 numbering (doc bit n = 31-n)
`define ITB_B_ADDR_LO 0
`define ITB_B_ADDR_HI 6
`define ITB_B_UNLK 24
`define ITB_B_EN 28
`define ITB_B_ALRT 29
`define ITB_B_CHAIN 31
`define ITB_B_PERIPHERAL_OFFSET_SIZE 30
`define ITB_B_BOOT_PAGE_INCREMENT 29
`define ITB_B_BOOT_DEVICE_LOW_BITS_UNLOCK 28
`define ITB_B_BADDR_LO 16
`define ITB_B_BADDR_HI 22
`define ITB_B_PMODE 15
`define ITB_B_PADDR_HI 12
`define ITB_TGT_MASK 32'h3100_007F
`define ITB_BOOT_MASK 32'hF07F_FFFF
`endif

// file: inc/itb_pkg.sv
package itb_pkg;
    typedef enum logic [1:0] {
        ITB_IDLE = 2'b00,
        ITB_LOAD = 2'b01,
        ITB_DONE = 2'b11
    } itb_state_e;
    typedef logic [31:0] itb_word_t;
endpackage

// file: tb/itb_loader_model.sv
`timescale 1ns/1ps
`default_nettype none
// EEPROM loader stand-in: two words per boot pass, the second is the last of the sequence
module itb_loader_model (
    input wire logic pclk,
    input wire logic boot_start,
    input wire itb_pkg::itb_word_t w0,
    input wire itb_pkg::itb_word_t w1,
    output logic load_we,
    output itb_pkg::itb_word_t load_data,
    output logic load_count_zero,
    output logic load_finished
);
    import itb_pkg::*;
    initial begin
        load_we = 1'b0;
        load_data = 32'h0000_0000;
        load_count_zero = 1'b0;
        load_finished = 1'b0;
    end
    // Slow answer, count only zero on the last word; data inverted once stale
    always begin
        @(posedge pclk);
        if (boot_start === 1'b1) begin
            load_finished <= 1'b0;
            repeat (12) @(posedge pclk);
            load_we <= 1'b1;
            load_data <= w0;
            load_count_zero <= 1'b0;
            @(posedge pclk);
            load_we <= 1'b0;
            load_data <= ~w0;
            @(posedge pclk);
            load_we <= 1'b1;
            load_data <= w1;
            load_count_zero <= 1'b1;
            @(posedge pclk);
            load_we <= 1'b0;
            load_data <= ~w1;
            load_count_zero <= 1'b0;
            load_finished <= !w1[31]; // Finished only when not chaining on
        end
    end
endmodule // itb_loader_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "itb_params.svh"
module testbench;
    import itb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_read, alert_pending, bus_ack, boot_peripheral_offset_size_pin;
    logic [31:0] paddr;
    itb_word_t pwdata, prdata, load_data, w0, w1, q;
    logic [1:0] addr_pins, boot_addr_pins;
    logic [6:0] bus_addr, boot_device_address;
    logic load_we, load_count_zero, load_finished, boot_start, boot_offset_size, boot_active, e;
    logic [12:0] boot_offset;
    int err_total, comparisons, starts;
    itb_boot_chain dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .addr_pins(addr_pins), .boot_addr_pins(boot_addr_pins), .boot_peripheral_offset_size_pin(boot_peripheral_offset_size_pin),
        .bus_addr(bus_addr), .bus_read(bus_read), .alert_pending(alert_pending), .bus_ack(bus_ack),
        .load_we(load_we), .load_data(load_data), .load_count_zero(load_count_zero),
        .load_finished(load_finished), .boot_start(boot_start), .boot_device_address(boot_device_address),
        .boot_offset_size(boot_offset_size), .boot_offset(boot_offset), .boot_active(boot_active));
    itb_loader_model ldr (.pclk(pclk), .boot_start(boot_start), .w0(w0), .w1(w1), .load_we(load_we),
        .load_data(load_data), .load_count_zero(load_count_zero), .load_finished(load_finished));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Counts start pulses so a one-cycle pulse is never missed
    always @(posedge pclk) if (boot_start === 1'b1) starts <= starts + 1;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Setup then access; request held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] a, input itb_word_t d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin err_total++; wrap_up(); end
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_for(input int cond_kind);
        int n;
        for (n = 0; n < 2000; n++) begin
            @(posedge pclk);
            if (cond_kind == 0 && starts == 2) break;
            if (cond_kind == 1 && boot_active === 1'b0) break;
        end
        if (n == 2000) begin err_total++; wrap_up(); end
    endtask
    task automatic t_reset_values();
        apb(1'b0, `ITB_OFF_TGT_CFG, 32'h0);
        cmp(q, 32'h1000_0032, "target cfg reset");
        apb(1'b0, `ITB_OFF_BOOT, 32'h0);
        cmp(q, 32'h6003_0000, "boot ctl reset");
        cmp({boot_offset_size, boot_device_address}, {1'b1, 7'h03}, "first source");
        cmp(starts, 1, "boot started");
    endtask
    task automatic t_chain();
        wait_for(0);
        w1 <= 32'h1050_0123;
        cmp({boot_offset_size, boot_device_address, boot_offset}, {1'b0, 7'h50, 13'h0123}, "chained");
        wait_for(1);
        cmp(starts, 2, "chain only at zero count");
        apb(1'b0, `ITB_OFF_STATUS, 32'h0);
        cmp(q[1:0], 2'b11, "boot done");
        apb(1'b1, `ITB_OFF_BOOT, 32'h8060_0010);
        apb(1'b0, `ITB_OFF_BOOT, 32'h0);
        cmp(q, 32'h8060_0010, "boot ctl still rw");
        cmp({starts[3:0], boot_device_address}, {4'd2, 7'h50}, "no effect after boot");
    endtask
    task automatic t_lock_and_match();
        apb(1'b1, `ITB_OFF_TGT_CFG, 32'h1000_0045); // never an all-zero own address
        apb(1'b0, `ITB_OFF_TGT_CFG, 32'h0);
        cmp(q, 32'h1000_0046, "low bits locked");
        apb(1'b1, `ITB_OFF_TGT_CFG, 32'h1100_0045);
        apb(1'b0, `ITB_OFF_TGT_CFG, 32'h0);
        cmp(q, 32'h1000_0045, "low bits unlocked");
        bus_addr <= 7'h45; bus_read <= 1'b0;
        @(posedge pclk) #1 cmp(bus_ack, 1'b1, "own address");
        bus_addr <= 7'h00;
        @(posedge pclk) #1 cmp(bus_ack, 1'b0, "general call");
        apb(1'b1, `ITB_OFF_TGT_CFG, 32'h2000_0045);
        bus_addr <= 7'h45;
        @(posedge pclk) #1 cmp(bus_ack, 1'b0, "disabled");
        bus_addr <= `ITB_ALERT_ADDR; bus_read <= 1'b1; alert_pending <= 1'b1;
        @(posedge pclk) #1 cmp(bus_ack, 1'b1, "alert read while disabled");
        alert_pending <= 1'b0;
        @(posedge pclk) #1 cmp(bus_ack, 1'b0, "alert not pending");
        apb(1'b0, 32'h0001_D150, 32'h0);
        cmp({e, q}, {1'b1, 32'h0}, "unmapped");
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
        addr_pins = 2'b10; boot_addr_pins = 2'b11; boot_peripheral_offset_size_pin = 1'b1;
        bus_addr = 7'h00; bus_read = 1'b0; alert_pending = 1'b0;
        w0 = 32'h9051_0077; w1 = 32'h9050_0123;
        err_total = 0; comparisons = 0; starts = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_chain();
        t_lock_and_match();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

// file: verilog/itb_addr_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "itb_params.svh"
// Decides whether an incoming bus address is acknowledged
module itb_addr_match (
    input wire logic [6:0] bus_addr,
    input wire logic bus_read,
    input wire logic [6:0] own_target_address,
    input wire logic target_response_enable,
    input wire logic alert_response_enable,
    input wire logic alert_pending,
    output logic ack
);
    logic is_alert;
    // Alert read wins over own address when enabled
    always_comb begin
        is_alert = alert_response_enable && alert_pending && bus_read && (bus_addr == `ITB_ALERT_ADDR);
        ack = 1'b0;
        if (is_alert) begin
            ack = 1'b1;
        end else if (bus_addr == `ITB_GCALL_ADDR) begin
            ack = 1'b0;
        end else if (target_response_enable && bus_addr == own_target_address) begin
            ack = 1'b1;
        end
    end
endmodule // itb_addr_match
`default_nettype wire

// file: verilog/itb_boot_chain.sv
`timescale 1ns/1ps
`default_nettype none
`include "itb_params.svh"
// Target address register and boot-load chain control
module itb_boot_chain (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire itb_pkg::itb_word_t pwdata,
    output itb_pkg::itb_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] addr_pins,
    input wire logic [1:0] boot_addr_pins,
    input wire logic boot_peripheral_offset_size_pin,
    input wire logic [6:0] bus_addr,
    input wire logic bus_read,
    input wire logic alert_pending,
    output logic bus_ack,
    input wire logic load_we,
    input wire itb_pkg::itb_word_t load_data,
    input wire logic load_count_zero,
    input wire logic load_finished,
    output logic boot_start,
    output logic [6:0] boot_device_address,
    output logic boot_offset_size,
    output logic [12:0] boot_offset,
    output logic boot_active
);
    import itb_pkg::*;

    itb_word_t tgt_cfg, next_tgt_cfg;
    itb_word_t boot_ctl, next_boot_ctl;
    itb_state_e state, next_state;
    logic captured, next_captured;
    logic next_boot_start;
    logic [6:0] next_boot_device_address;
    logic next_boot_offset_size;
    logic [12:0] next_boot_offset;
    itb_word_t next_prdata;
    logic wr, rd, hit;

    // Locked low bits keep their old value unless the unlock bit is in the data
    function automatic itb_word_t merge_locked(input itb_word_t old_v, input itb_word_t new_v,
                                               input int lo, input int unlk);
        itb_word_t r;
        r = new_v;
        if (!new_v[unlk]) begin
            r[lo+1 -: 2] = old_v[lo+1 -: 2];
        end
        return r;
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign hit = (paddr == `ITB_OFF_TGT_CFG) || (paddr == `ITB_OFF_BOOT) || (paddr == `ITB_OFF_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign boot_active = (state == ITB_LOAD);

    // Register and boot sequencer next values
    always_comb begin
        next_tgt_cfg = tgt_cfg;
        next_boot_ctl = boot_ctl;
        next_state = state;
        next_captured = 1'b1;
        next_boot_start = 1'b0;
        next_boot_device_address = boot_device_address;
        next_boot_offset_size = boot_offset_size;
        next_boot_offset = boot_offset;
        next_prdata = prdata;
        if (!captured) begin
            next_tgt_cfg[`ITB_B_ADDR_LO+1 -: 2] = addr_pins;
            next_boot_ctl[`ITB_B_BADDR_LO+1 -: 2] = boot_addr_pins;
            next_boot_ctl[`ITB_B_PERIPHERAL_OFFSET_SIZE] = boot_peripheral_offset_size_pin;
        end
        if (wr && paddr == `ITB_OFF_TGT_CFG) begin
            next_tgt_cfg = merge_locked(tgt_cfg, pwdata, `ITB_B_ADDR_LO, `ITB_B_UNLK) & `ITB_TGT_MASK;
            next_tgt_cfg[`ITB_B_UNLK] = 1'b0;
        end
        if (wr && paddr == `ITB_OFF_BOOT) begin
            next_boot_ctl = merge_locked(boot_ctl, pwdata, `ITB_B_BADDR_LO, `ITB_B_BOOT_DEVICE_LOW_BITS_UNLOCK) & `ITB_BOOT_MASK;
        end
        unique case (state)
            ITB_IDLE: begin
                if (captured) begin
                    next_state = ITB_LOAD;
                    next_boot_start = 1'b1;
                    next_boot_device_address = boot_ctl[`ITB_B_BADDR_HI:`ITB_B_BADDR_LO];
                    next_boot_offset_size = boot_ctl[`ITB_B_PERIPHERAL_OFFSET_SIZE];
                    next_boot_offset = boot_ctl[`ITB_B_PADDR_HI:0];
                end
            end
            ITB_LOAD: begin
                if (load_we) begin
                    next_boot_ctl = merge_locked(boot_ctl, load_data, `ITB_B_BADDR_LO, `ITB_B_BOOT_DEVICE_LOW_BITS_UNLOCK)
                                    & `ITB_BOOT_MASK;
                    if (load_data[`ITB_B_CHAIN] && load_count_zero) begin
                        next_boot_start = 1'b1;
                        next_boot_device_address = next_boot_ctl[`ITB_B_BADDR_HI:`ITB_B_BADDR_LO];
                        next_boot_offset_size = next_boot_ctl[`ITB_B_PERIPHERAL_OFFSET_SIZE];
                        next_boot_offset = next_boot_ctl[`ITB_B_PADDR_HI:0];
                    end else if (load_count_zero && load_finished) begin
                        next_state = ITB_DONE;
                    end
                end else if (load_finished) begin
                    next_state = ITB_DONE;
                end
            end
            ITB_DONE: begin
                next_state = ITB_DONE;
            end
            default: next_state = ITB_IDLE;
        endcase
        // Read data captured in setup phase
        if (rd) begin
            if (paddr == `ITB_OFF_TGT_CFG) begin
                next_prdata = tgt_cfg;
            end else if (paddr == `ITB_OFF_BOOT) begin
                next_prdata = boot_ctl;
            end else if (paddr == `ITB_OFF_STATUS) begin
                next_prdata = {30'h0000_0000, state};
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_cfg <= `ITB_TGT_RST;
            boot_ctl <= `ITB_BOOT_RST;
            state <= ITB_IDLE;
            captured <= 1'b0;
            boot_start <= 1'b0;
            boot_device_address <= 7'h00;
            boot_offset_size <= 1'b0;
            boot_offset <= 13'h0000;
            prdata <= 32'h0000_0000;
        end else begin
            tgt_cfg <= next_tgt_cfg;
            boot_ctl <= next_boot_ctl;
            state <= next_state;
            captured <= next_captured;
            boot_start <= next_boot_start;
            boot_device_address <= next_boot_device_address;
            boot_offset_size <= next_boot_offset_size;
            boot_offset <= next_boot_offset;
            prdata <= next_prdata;
        end
    end

    itb_addr_match u_match (
        .bus_addr(bus_addr),
        .bus_read(bus_read),
        .own_target_address(tgt_cfg[`ITB_B_ADDR_HI:`ITB_B_ADDR_LO]),
        .target_response_enable(tgt_cfg[`ITB_B_EN]),
        .alert_response_enable(tgt_cfg[`ITB_B_ALRT]),
        .alert_pending(alert_pending),
        .ack(bus_ack)
    );

    // General call never acknowledged
    a_gcall_nack: assert property (@(posedge pclk) disable iff (!presetn)
        (bus_addr == `ITB_GCALL_ADDR) |-> !bus_ack) else $error("general call acked");
    a_disabled_nack: assert property (@(posedge pclk) disable iff (!presetn)
        (!tgt_cfg[`ITB_B_EN] && !(bus_read && bus_addr == `ITB_ALERT_ADDR)) |-> !bus_ack)
        else $error("ack while disabled");
    a_own_ack: assert property (@(posedge pclk) disable iff (!presetn)
        (tgt_cfg[`ITB_B_EN] && bus_addr == tgt_cfg[`ITB_B_ADDR_HI:`ITB_B_ADDR_LO]
         && bus_addr != `ITB_ALERT_ADDR && bus_addr != `ITB_GCALL_ADDR)
        |-> bus_ack) else $error("own address not acked");
    a_lock_low: assert property (@(posedge pclk) disable iff (!presetn)
        (captured && wr && paddr == `ITB_OFF_TGT_CFG && !pwdata[`ITB_B_UNLK])
        |=> tgt_cfg[1:0] == $past(tgt_cfg[1:0])) else $error("locked bits changed");
    a_boot_first: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ITB_IDLE && captured) |=> boot_start && state == ITB_LOAD) else $error("boot not started");
    a_pin_cap: assert property (@(posedge pclk) disable iff (!presetn)
        !captured |=> tgt_cfg[1:0] == $past(addr_pins)) else $error("pins not captured");
    a_chain_go: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ITB_LOAD && load_we && load_data[`ITB_B_CHAIN] && load_count_zero) |=> boot_start)
        else $error("chain missed");
    a_no_chain: assert property (@(posedge pclk) disable iff (!presetn)
        (state != ITB_IDLE && !(state == ITB_LOAD && load_we && load_data[`ITB_B_CHAIN] && load_count_zero))
        |=> !boot_start) else $error("spurious restart");
    a_done_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        state == ITB_DONE |=> $stable(boot_device_address) && state == ITB_DONE) else $error("boot moved");
endmodule // itb_boot_chain
`default_nettype wire
